// ==== inc/irap_cfg.svh ====
// Timing counts, bus address and reset values for the register access port
`ifndef IRAP_CFG_SVH
`define IRAP_CFG_SVH

// ****************************************
// Bus addressing
// ****************************************
// Chip address value is arbitrary
`define IRAP_DEV_ADDR 7'h2a
`define IRAP_PTR_RST 8'h00
`define IRAP_BYTE_BITS 4'h8

// ****************************************
// Timing
// ****************************************
`define IRAP_CLK_PERIOD_NS 8
`define IRAP_SCL_STD_NS 10000
`define IRAP_SCL_FAST_NS 2500
`define IRAP_DIV_W 12

`endif

// ==== inc/irap_pkg.sv ====
// Types shared by both ends of the register access port
`default_nettype none

package irap_pkg;

  typedef enum logic [1:0] {
    IRAP_CMD_START = 2'h0,
    IRAP_CMD_WRITE = 2'h1,
    IRAP_CMD_READ = 2'h2,
    IRAP_CMD_STOP = 2'h3
  } irap_cmd_type;

  typedef enum logic [2:0] {
    IRAP_S_IDLE = 3'h0,
    IRAP_S_ADDR = 3'h1,
    IRAP_S_ACK = 3'h3,
    IRAP_S_RX = 3'h2,
    IRAP_S_TX = 3'h6,
    IRAP_S_TXACK = 3'h7,
    IRAP_S_WAIT = 3'h5
  } irap_sstate_type;

  typedef enum logic [1:0] {
    IRAP_M_IDLE = 2'h0,
    IRAP_M_START = 2'h1,
    IRAP_M_BIT = 2'h3,
    IRAP_M_STOP = 2'h2
  } irap_mstate_type;

endpackage : irap_pkg

`default_nettype wire

// ==== inc/irap_if.sv ====
// Two-wire bus joining the master end and the slave end
`default_nettype none

interface irap_if;
  // Pull-down enables of each party
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_s;
  // Resolved wire levels, pulled up when nobody drives
  logic scl;
  logic sda;

  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);

  modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport slave (output sda_oe_s, input scl, input sda);
endinterface : irap_if

`default_nettype wire

// ==== design/irap_slave.sv ====
// Slave end: bus protocol, register pointer and 16-bit byte latches
`include "irap_cfg.svh"
`default_nettype none

module irap_slave #(
  parameter logic [6:0] DEV_ADDR = `IRAP_DEV_ADDR
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Bus side
  irap_if.slave bus,
  // Register file side
  output logic [7:0] reg_addr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] reg_rdata_hi,
  input wire logic reg_wide,
  output logic reg_wr,
  output logic reg_wr_wide,
  output logic [7:0] reg_wr_addr,
  output logic [15:0] reg_wdata
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    irap_pkg::irap_sstate_type st;
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic rw, first, mack;
    logic [7:0] ptr;
    logic [7:0] lat_hi;
    logic [7:0] lat_addr;
    logic lat_ok;
    logic [7:0] wlo;
    logic [7:0] wadr;
    logic wpend;
    logic sda_oe;
    logic rd, wr, wr_wide;
    logic [7:0] wr_addr;
    logic [15:0] wdata;
  } irap_slave_state_type;

  irap_slave_state_type state_reg;
  irap_slave_state_type state_next;
  logic rise, fall, start_c, stop_c;

  // Edges are taken only from the second synchroniser stage
  assign rise = state_reg.scl_s2 & ~state_reg.scl_d;
  assign fall = ~state_reg.scl_s2 & state_reg.scl_d;
  assign start_c = state_reg.scl_s2 & state_reg.scl_d & state_reg.sda_d & ~state_reg.sda_s2;
  assign stop_c = state_reg.scl_s2 & state_reg.scl_d & ~state_reg.sda_d & state_reg.sda_s2;

  assign bus.sda_oe_s = state_reg.sda_oe;
  assign reg_addr = state_reg.ptr;
  assign reg_rd = state_reg.rd;
  assign reg_wr = state_reg.wr;
  assign reg_wr_wide = state_reg.wr_wide;
  assign reg_wr_addr = state_reg.wr_addr;
  assign reg_wdata = state_reg.wdata;

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction : inc8

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic load;
    load = 1'b0;
    state_next = state_reg;
    state_next.rd = 1'b0;
    state_next.wr = 1'b0;
    state_next.scl_s1 = bus.scl;
    state_next.scl_s2 = state_reg.scl_s1;
    state_next.scl_d = state_reg.scl_s2;
    state_next.sda_s1 = bus.sda;
    state_next.sda_s2 = state_reg.sda_s1;
    state_next.sda_d = state_reg.sda_s2;
    if (start_c)
    begin
      state_next.st = irap_pkg::IRAP_S_ADDR;
      state_next.bitcnt = 4'h0;
      state_next.sda_oe = 1'b0;
      state_next.wpend = 1'b0;
    end
    else if (stop_c)
    begin
      // Pointer is left untouched so the next transaction resumes here
      state_next.st = irap_pkg::IRAP_S_IDLE;
      state_next.sda_oe = 1'b0;
      state_next.wpend = 1'b0;
    end
    else
    begin
      case (state_reg.st)
        irap_pkg::IRAP_S_ADDR, irap_pkg::IRAP_S_RX:
        begin
          if (rise)
          begin
            state_next.sh = {state_reg.sh[6:0], state_reg.sda_s2};
            state_next.bitcnt = state_reg.bitcnt + 4'h1;
          end
          else if (fall && state_reg.bitcnt == `IRAP_BYTE_BITS)
          begin
            state_next.bitcnt = 4'h0;
            if (state_reg.st == irap_pkg::IRAP_S_ADDR)
            begin
              if (state_reg.sh[7:1] == DEV_ADDR)
              begin
                state_next.rw = state_reg.sh[0];
                state_next.first = ~state_reg.sh[0];
                state_next.sda_oe = 1'b1;
                state_next.st = irap_pkg::IRAP_S_ACK;
              end
              else
                state_next.st = irap_pkg::IRAP_S_WAIT;
            end
            else
            begin
              state_next.sda_oe = 1'b1;
              state_next.st = irap_pkg::IRAP_S_ACK;
              if (state_reg.first)
              begin
                state_next.ptr = state_reg.sh;
                state_next.first = 1'b0;
              end
              else
              begin
                state_next.ptr = inc8(state_reg.ptr);
                if (state_reg.wpend && state_reg.ptr == state_reg.wadr)
                begin
                  // High byte commits both halves in one strobe
                  state_next.wr = 1'b1;
                  state_next.wr_wide = 1'b1;
                  state_next.wr_addr = state_reg.wadr - 8'h01;
                  state_next.wdata = {state_reg.sh, state_reg.wlo};
                  state_next.wpend = 1'b0;
                end
                else if (reg_wide)
                begin
                  // Low byte is held back until its partner arrives
                  state_next.wlo = state_reg.sh;
                  state_next.wadr = inc8(state_reg.ptr);
                  state_next.wpend = 1'b1;
                end
                else
                begin
                  state_next.wr = 1'b1;
                  state_next.wr_wide = 1'b0;
                  state_next.wr_addr = state_reg.ptr;
                  state_next.wdata = {8'h00, state_reg.sh};
                  state_next.wpend = 1'b0;
                end
              end
            end
          end
        end
        irap_pkg::IRAP_S_ACK:
        begin
          if (fall)
          begin
            state_next.sda_oe = 1'b0;
            state_next.bitcnt = 4'h0;
            if (state_reg.rw)
              load = 1'b1;
            else
              state_next.st = irap_pkg::IRAP_S_RX;
          end
        end
        irap_pkg::IRAP_S_TX:
        begin
          if (fall)
          begin
            state_next.bitcnt = state_reg.bitcnt + 4'h1;
            if (state_reg.bitcnt + 4'h1 == `IRAP_BYTE_BITS)
            begin
              state_next.sda_oe = 1'b0;
              state_next.ptr = inc8(state_reg.ptr);
              state_next.st = irap_pkg::IRAP_S_TXACK;
            end
            else
            begin
              state_next.sh = {state_reg.sh[6:0], 1'b0};
              state_next.sda_oe = ~state_reg.sh[6];
            end
          end
        end
        irap_pkg::IRAP_S_TXACK:
        begin
          if (rise)
            state_next.mack = ~state_reg.sda_s2;
          else if (fall)
          begin
            state_next.bitcnt = 4'h0;
            // Not-acknowledge: leave the data line alone until START or STOP
            if (state_reg.mack)
              load = 1'b1;
            else
              state_next.st = irap_pkg::IRAP_S_WAIT;
          end
        end
        default:
          state_next.sda_oe = 1'b0;
      endcase
    end
    // ****************************************
    // Fetch of the next byte to send
    // ****************************************
    if (load)
    begin
      state_next.st = irap_pkg::IRAP_S_TX;
      state_next.rd = 1'b1;
      state_next.lat_ok = 1'b0;
      if (state_reg.lat_ok && state_reg.ptr == state_reg.lat_addr)
        state_next.sh = state_reg.lat_hi;
      else
      begin
        state_next.sh = reg_rdata;
        if (reg_wide)
        begin
          // Freezes the high half so a carry between reads cannot tear it
          state_next.lat_hi = reg_rdata_hi;
          state_next.lat_addr = inc8(state_reg.ptr);
          state_next.lat_ok = 1'b1;
        end
      end
      state_next.sda_oe = ~state_next.sh[7];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '{st: irap_pkg::IRAP_S_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                     sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, ptr: `IRAP_PTR_RST, default: '0};
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

endmodule : irap_slave

`default_nettype wire

// ==== design/irap_master.sv ====
// Master end: byte-level command engine that drives the two-wire bus
`include "irap_cfg.svh"
`default_nettype none

module irap_master #(
  parameter int SCL_PERIOD_NS = `IRAP_SCL_FAST_NS,
  parameter int CLK_PERIOD_NS = `IRAP_CLK_PERIOD_NS
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Bus side
  irap_if.master bus,
  // Command side
  input wire logic cmd_valid,
  input wire irap_pkg::irap_cmd_type cmd,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_ready,
  output logic done,
  output logic [7:0] rx_data,
  output logic rx_ack
);

  // Quarter bit period rounded up, so the bus never runs faster than asked
  localparam int QUARTER_INT = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [`IRAP_DIV_W-1:0] QUARTER_M1 = `IRAP_DIV_W'(QUARTER_INT - 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    irap_pkg::irap_mstate_type st;
    irap_pkg::irap_cmd_type cmd;
    logic [`IRAP_DIV_W-1:0] div;
    logic [1:0] ph;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic nack;
    logic sda_s1;
    logic sda_s2;
    logic scl_oe;
    logic sda_oe;
    logic ready;
    logic done;
    logic [7:0] rx_data;
    logic rx_ack;
  } irap_master_state_type;

  irap_master_state_type state_reg;
  irap_master_state_type state_next;

  assign bus.scl_oe_m = state_reg.scl_oe;
  assign bus.sda_oe_m = state_reg.sda_oe;
  assign cmd_ready = state_reg.ready;
  assign done = state_reg.done;
  assign rx_data = state_reg.rx_data;
  assign rx_ack = state_reg.rx_ack;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic tick;
    logic last;
    logic wr;
    tick = (state_reg.div == QUARTER_M1);
    last = (state_reg.bitcnt == `IRAP_BYTE_BITS);
    wr = (state_reg.cmd == irap_pkg::IRAP_CMD_WRITE);
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.sda_s1 = bus.sda;
    state_next.sda_s2 = state_reg.sda_s1;
    if (state_reg.st == irap_pkg::IRAP_M_IDLE)
    begin
      if (cmd_valid)
      begin
        state_next.cmd = cmd;
        state_next.sh = cmd_data;
        state_next.nack = cmd_nack;
        state_next.ph = 2'h0;
        state_next.bitcnt = 4'h0;
        state_next.div = '0;
        state_next.ready = 1'b0;
        case (cmd)
          irap_pkg::IRAP_CMD_START: state_next.st = irap_pkg::IRAP_M_START;
          irap_pkg::IRAP_CMD_STOP: state_next.st = irap_pkg::IRAP_M_STOP;
          default: state_next.st = irap_pkg::IRAP_M_BIT;
        endcase
      end
    end
    else
    begin
      state_next.div = tick ? '0 : state_reg.div + `IRAP_DIV_W'(1);
      if (tick)
      begin
        state_next.ph = state_reg.ph + 2'h1;
        case (state_reg.st)
          irap_pkg::IRAP_M_START:
          begin
            // Also serves as repeated START between pointer write and read
            case (state_reg.ph)
              2'h0: state_next.sda_oe = 1'b0;
              2'h1: state_next.scl_oe = 1'b0;
              2'h2: state_next.sda_oe = 1'b1;
              default: state_next.scl_oe = 1'b1;
            endcase
          end
          irap_pkg::IRAP_M_STOP:
          begin
            // Allowed at any time, also right after a not-acknowledge
            case (state_reg.ph)
              2'h0: state_next.sda_oe = 1'b1;
              2'h1: state_next.scl_oe = 1'b0;
              2'h2: state_next.sda_oe = 1'b0;
              default: state_next.scl_oe = 1'b0;
            endcase
          end
          default:
          begin
            case (state_reg.ph)
              2'h0:
              begin
                if (wr)
                begin
                  state_next.sda_oe = last ? 1'b0 : ~state_reg.sh[7];
                end
                else
                begin
                  state_next.sda_oe = last ? ~state_reg.nack : 1'b0;
                end
              end
              2'h1: state_next.scl_oe = 1'b0;
              2'h2:
              begin
                if (last)
                begin
                  state_next.rx_ack = ~state_reg.sda_s2;
                end
                else if (!wr)
                begin
                  state_next.sh = {state_reg.sh[6:0], state_reg.sda_s2};
                end
              end
              default:
              begin
                state_next.scl_oe = 1'b1;
                state_next.bitcnt = state_reg.bitcnt + 4'h1;
                if (wr)
                begin
                  state_next.sh = {state_reg.sh[6:0], 1'b0};
                end
              end
            endcase
          end
        endcase
        if (state_reg.ph == 2'h3 && (state_reg.st != irap_pkg::IRAP_M_BIT || last))
        begin
          state_next.st = irap_pkg::IRAP_M_IDLE;
          state_next.ready = 1'b1;
          state_next.done = 1'b1;
          state_next.rx_data = state_reg.sh;
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= '{st: irap_pkg::IRAP_M_IDLE, cmd: irap_pkg::IRAP_CMD_START, sda_s1: 1'b1,
                     sda_s2: 1'b1, ready: 1'b1, default: '0};
    end
    else if (ce)
    begin
      state_reg <= state_next;
    end
  end

endmodule : irap_master

`default_nettype wire

// ==== verification/irap_assertions.sv ====
// Bus checker for the link between the master and slave ends
`include "irap_cfg.svh"
`default_nettype none

module irap_assertions #(
  parameter logic [6:0] DEV_ADDR = `IRAP_DEV_ADDR
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Link enables and wires
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, in_xfer, first_b, rd_mode, hit, nacked;
  logic [3:0] bit_cnt;
  logic [6:0] sh;
  logic scl_rise, start_ev, stop_ev;

  assign scl_rise = scl & ~scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;

  // Frames are tracked from the wires alone, so neither end is trusted
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_xfer <= 1'b0;
      first_b <= 1'b1;
      rd_mode <= 1'b0;
      hit <= 1'b0;
      nacked <= 1'b0;
      bit_cnt <= 4'h0;
      sh <= 7'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev || stop_ev)
      begin
        in_xfer <= start_ev;
        first_b <= 1'b1;
        nacked <= 1'b0;
        bit_cnt <= 4'h0;
      end
      else if (scl_rise && in_xfer)
      begin
        bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
        sh <= {sh[5:0], sda};
        if (bit_cnt == 4'h7 && first_b)
        begin
          rd_mode <= sda;
          hit <= (sh == DEV_ADDR);
        end
        if (bit_cnt == 4'h8)
        begin
          first_b <= 1'b0;
          nacked <= nacked | (rd_mode & hit & sda & ~first_b);
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence ninth_s;
    scl_rise && in_xfer && bit_cnt == 4'h8;
  endsequence

  sequence stop_s;
    stop_ev;
  endsequence

  slave_edge_safe_a: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("slave data moved while clock high");
  addr_ack_a: assert property (ninth_s ##0 (first_b && hit) |-> !sda && sda_oe_s)
    else $error("own address not acknowledged");
  addr_nack_a: assert property (ninth_s ##0 (first_b && !hit) |-> sda)
    else $error("foreign address acknowledged");
  addr_listen_a: assert property (in_xfer && first_b && bit_cnt != 4'h8 && scl |-> !sda_oe_s)
    else $error("slave drove during address bits");
  write_ack_a: assert property (ninth_s ##0 (!first_b && hit && !rd_mode) |-> sda_oe_s)
    else $error("written byte not acknowledged");
  read_slot_a: assert property (ninth_s ##0 (!first_b && hit && rd_mode) |-> !sda_oe_s)
    else $error("slave drove the master answer slot");
  nack_release_a: assert property (nacked |-> !sda_oe_s)
    else $error("slave drove after not-acknowledge");
  idle_release_a: assert property (!in_xfer |-> !sda_oe_s)
    else $error("slave drove an idle bus");
  stop_free_a: assert property (stop_s |=> !scl_oe_m [*8])
    else $error("clock pulled soon after stop");
endmodule : irap_assertions

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench: both link ends with a small register file model
`include "irap_cfg.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // Short link period keeps the run brief yet leaves 13 cycles a quarter for the sync flops
  localparam int SCL_NS = 400;
  localparam logic [7:0] AW = {`IRAP_DEV_ADDR, 1'b0};
  localparam logic [7:0] AR = {`IRAP_DEV_ADDR, 1'b1};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  irap_pkg::irap_cmd_type cmd = irap_pkg::IRAP_CMD_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic cmd_ready, done, rx_ack, reg_rd, reg_wr, reg_wr_wide;
  logic [7:0] rx_data, reg_addr, reg_wr_addr;
  logic [15:0] reg_wdata;
  logic [7:0] mem [256];
  logic [7:0] spoil_at = 8'hff;
  logic [24:0] wr_log = 25'h0000000;
  logic [7:0] wr_cnt = 8'h00;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  // Sixteen-bit fields sit at even addresses of the 0x90 row
  wire logic reg_wide = (reg_addr[7:4] == 4'h9) && !reg_addr[0];
  wire logic [7:0] reg_rdata = mem[reg_addr];
  wire logic [7:0] reg_rdata_hi = mem[reg_addr + 8'h01];

  irap_if bus_if ();
  irap_master #(.SCL_PERIOD_NS(SCL_NS), .CLK_PERIOD_NS(`IRAP_CLK_PERIOD_NS)) i_irap_master (
    .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .bus(bus_if.master),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .cmd_ready(cmd_ready), .done(done), .rx_data(rx_data), .rx_ack(rx_ack));
  irap_slave #(.DEV_ADDR(`IRAP_DEV_ADDR)) i_irap_slave (
    .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .bus(bus_if.slave),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_hi(reg_rdata_hi),
    .reg_wide(reg_wide), .reg_wr(reg_wr), .reg_wr_wide(reg_wr_wide), .reg_wr_addr(reg_wr_addr),
    .reg_wdata(reg_wdata));
  irap_assertions #(.DEV_ADDR(`IRAP_DEV_ADDR)) i_irap_assertions (
    .ref_clk(ref_clk), .resetn(resetn), .scl_oe_m(bus_if.scl_oe_m), .sda_oe_m(bus_if.sda_oe_m),
    .sda_oe_s(bus_if.sda_oe_s), .scl(bus_if.scl), .sda(bus_if.sda));

  always #4 ref_clk = ~ref_clk;

  // Register file; a fetch at spoil_at alters the byte above so only a latch can deliver it
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (reg_rd && reg_addr == spoil_at)
      mem[reg_addr + 8'h01] <= ~mem[reg_addr + 8'h01];
    if (reg_wr)
    begin
      wr_cnt <= wr_cnt + 8'h01;
      wr_log <= {reg_wr_wide, reg_wr_addr, reg_wdata};
    end
    if (cycles == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [24:0] exp, input logic [24:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One command: raised just after an edge, held to the accepting edge, then done awaited
  task automatic op(input irap_pkg::irap_cmd_type c, input logic [7:0] d, input logic nk);
    int n;
    while (cmd_ready !== 1'b1)
      @(posedge ref_clk);
    cmd <= c;
    cmd_data <= d;
    cmd_nack <= nk;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 2000 && done !== 1'b1; n++)
      @(posedge ref_clk);
    if (done !== 1'b1)
    begin
      // A command that never finishes is a failure, not a silent skip
      error_cnt++;
      report_and_stop();
    end
  endtask : op

  task automatic bus_start();
    op(irap_pkg::IRAP_CMD_START, 8'h00, 1'b0);
  endtask : bus_start

  task automatic bus_stop();
    op(irap_pkg::IRAP_CMD_STOP, 8'h00, 1'b0);
  endtask : bus_stop

  task automatic wr_b(input logic [7:0] d, input logic ack);
    op(irap_pkg::IRAP_CMD_WRITE, d, 1'b0);
    chk("ack", 25'(ack), 25'(rx_ack));
  endtask : wr_b

  task automatic rd_b(input logic nk, input logic [7:0] exp);
    op(irap_pkg::IRAP_CMD_READ, 8'h00, nk);
    chk("read data", 25'(exp), 25'(rx_data));
  endtask : rd_b

  task automatic t_write_byte();
    chk("pointer at reset", 25'(`IRAP_PTR_RST), 25'(reg_addr));
    bus_start();
    wr_b(AW, 1'b1);
    wr_b(8'h10, 1'b1);
    wr_b(8'h55, 1'b1);
    bus_stop();
    chk("write strobe", {1'b0, 8'h10, 16'h0055}, wr_log);
    chk("write count", 25'h1, 25'(wr_cnt));
    chk("pointer after stop", 25'h11, 25'(reg_addr));
    $display("t_write_byte done");
  endtask : t_write_byte

  task automatic t_write_wide();
    bus_start();
    wr_b(AW, 1'b1);
    wr_b(8'h90, 1'b1);
    wr_b(8'h34, 1'b1);
    chk("low byte held", 25'h1, 25'(wr_cnt));
    wr_b(8'h12, 1'b1);
    bus_stop();
    chk("wide strobe", {1'b1, 8'h90, 16'h1234}, wr_log);
    chk("write count", 25'h2, 25'(wr_cnt));
    chk("pointer after burst", 25'h92, 25'(reg_addr));
    $display("t_write_wide done");
  endtask : t_write_wide

  task automatic t_read_wide();
    logic [7:0] lo;
    logic [7:0] hi;
    lo = mem[8'h94];
    hi = mem[8'h95];
    spoil_at = 8'h94;
    bus_start();
    wr_b(AW, 1'b1);
    wr_b(8'h94, 1'b1);
    bus_start();
    wr_b(AR, 1'b1);
    rd_b(1'b0, lo);
    rd_b(1'b1, hi);
    bus_stop();
    chk("pointer after read", 25'h96, 25'(reg_addr));
    $display("t_read_wide done");
  endtask : t_read_wide

  task automatic t_read_next();
    bus_start();
    wr_b(AR, 1'b1);
    rd_b(1'b0, mem[8'h96]);
    rd_b(1'b1, mem[8'h97]);
    bus_stop();
    chk("pointer after read", 25'h98, 25'(reg_addr));
    $display("t_read_next done");
  endtask : t_read_next

  task automatic t_wrong_addr();
    bus_start();
    wr_b({`IRAP_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
    wr_b(8'h20, 1'b0);
    bus_stop();
    chk("write count", 25'h2, 25'(wr_cnt));
    chk("pointer kept", 25'h98, 25'(reg_addr));
    $display("t_wrong_addr done");
  endtask : t_wrong_addr

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_write_byte();
    t_write_wide();
    t_read_wide();
    t_read_next();
    t_wrong_addr();
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
